//--- rtl/ura_map.svh
// constants for the ulpi register access block
`ifndef URA_MAP_SVH
`define URA_MAP_SVH

// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define URA_KIND_MSB   7
`define URA_KIND_LSB   6
`define URA_FIELD_MSB  5
`define URA_PID_MSB    3
`define URA_IDLE_BYTE  8'h00
`define URA_EXT_ADDR   6'h2f
`define URA_NOPID_LOW  6'h00

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define URA_BYTE_RST   8'h00
`define URA_PID_RST    4'h0

`endif

//--- rtl/ura_pkg.sv
// types shared by the ulpi register access block
`default_nettype none

package ura_pkg;

  // command class held in the two top bits of the command byte
  typedef enum logic [1:0] {
    URA_K_IDLE = 2'b00,
    URA_K_TX   = 2'b01,
    URA_K_WR   = 2'b10,
    URA_K_RD   = 2'b11
  } ura_kind_t;

  // decoded command byte
  typedef struct packed {
    ura_kind_t   kind;
    logic        ext;
    logic        nopid;
    logic        pid_ok;
    logic [3:0]  pid;
    logic [7:0]  addr;
  } ura_cmd_t;

  // protocol sequencer states
  typedef enum logic [3:0] {
    URA_S_IDLE   = 4'b0000,
    URA_S_CMD    = 4'b0001,
    URA_S_ACK    = 4'b0010,
    URA_S_EADDR  = 4'b0011,
    URA_S_WDATA  = 4'b0100,
    URA_S_WSTP   = 4'b0101,
    URA_S_COMMIT = 4'b0110,
    URA_S_RTURN  = 4'b0111,
    URA_S_RDRIVE = 4'b1000,
    URA_S_RBACK  = 4'b1001,
    URA_S_TXPKT  = 4'b1010
  } ura_state_t;

endpackage : ura_pkg

`default_nettype wire

//--- rtl/ura_cmd_decode.sv
// combinational decoder for the link's command byte
`include "ura_map.svh"
`default_nettype none

module ura_cmd_decode
  import ura_pkg::*;
(
  // raw byte from the bus
  input  wire logic [7:0] cmd_byte,
  // decoded view
  output ura_cmd_t        cmd
);

  // ----------------------------------------------------------------
  // field helpers
  // ----------------------------------------------------------------
  function automatic logic low_is(input logic [7:0] b, input logic [5:0] v);
    return b[`URA_FIELD_MSB:0] == v;
  endfunction : low_is

  wire ura_kind_t kind   = ura_kind_t'(cmd_byte[`URA_KIND_MSB:`URA_KIND_LSB]);
  wire logic      is_reg = cmd_byte[`URA_KIND_MSB];

  assign cmd.kind   = kind;
  assign cmd.ext    = is_reg && low_is(cmd_byte, `URA_EXT_ADDR);
  assign cmd.nopid  = (kind == URA_K_TX) && low_is(cmd_byte, `URA_NOPID_LOW);
  // pid only valid with bits 5:4 clear, bit 3 is the msb
  assign cmd.pid_ok = (kind == URA_K_TX) && (cmd_byte[5:4] == 2'b00);
  assign cmd.pid    = cmd_byte[`URA_PID_MSB:0];
  // immediate address in bits 5:0, zero extended
  assign cmd.addr   = {2'b00, cmd_byte[`URA_FIELD_MSB:0]};

endmodule : ura_cmd_decode

`default_nettype wire

//--- rtl/ura_regmem.sv
// register array with registered read data
`include "ura_map.svh"
`default_nettype none

module ura_regmem (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // write port
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  // read port
  input  wire logic       re,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);

  // contents have no reset so power modes never disturb them
  logic [7:0] mem [0:255];

  always_ff @(posedge clk_sys) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= `URA_BYTE_RST;
    end else if (clk_en && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : ura_regmem

`default_nettype wire

//--- rtl/ura_ulpi_regacc.sv
// ulpi register access sequencer of the transceiver side
`include "ura_map.svh"
`default_nettype none

module ura_ulpi_regacc
  import ura_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // ulpi bus, two-way data pins
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            dir,
  output logic            nxt,
  input  wire logic       stp,
  // transmit command notice to the packet path
  output logic            tx_start,
  output logic            tx_nopid,
  output logic      [3:0] tx_pid,
  // register write notice to the rest of the transceiver
  output logic            reg_wr,
  output logic      [7:0] reg_wr_addr,
  output logic      [7:0] reg_wr_data
);

  // ----------------------------------------------------------------
  // state and captured fields
  // ----------------------------------------------------------------
  ura_state_t state;
  ura_state_t next_state;
  ura_cmd_t   cmd_now;
  ura_kind_t  kind;
  logic       ext;
  logic [7:0] addr;
  logic [7:0] wdata;

  ura_cmd_decode u_dec (
    .cmd_byte (data_in),
    .cmd      (cmd_now)
  );

  // ----------------------------------------------------------------
  // decode of bus conditions
  // ----------------------------------------------------------------
  // a command is only looked for while idle, which excludes the
  // turnaround cycle because rback always sits between
  wire logic cmd_seen  = (state == URA_S_IDLE) && (cmd_now.kind != URA_K_IDLE);
  wire logic is_wr     = (kind == URA_K_WR);
  wire logic is_rd     = (kind == URA_K_RD);
  wire logic tx_legal  = cmd_now.nopid || cmd_now.pid_ok;
  wire logic take_addr = (state == URA_S_EADDR);
  wire logic take_data = (state == URA_S_WDATA);
  wire logic mem_we    = (state == URA_S_COMMIT);
  wire logic mem_re    = (state == URA_S_RTURN);

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // nxt high from t2 until the byte before the end; extended write
  // drops it one cycle earlier relative to the data byte
  assign nxt = (state == URA_S_ACK) || (state == URA_S_EADDR) ||
               (state == URA_S_WDATA) ||
               ((state == URA_S_WSTP) && !ext);
  // dir only for the two read cycles, never during writes
  assign dir = (state == URA_S_RTURN) || (state == URA_S_RDRIVE);
  // rturn is the turnaround, so the bus is driven in rdrive only
  assign data_oe = (state == URA_S_RDRIVE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      URA_S_IDLE: begin
        if (cmd_seen && cmd_now.kind == URA_K_TX) begin
          next_state = tx_legal ? URA_S_TXPKT : URA_S_IDLE;
        end else if (cmd_seen) begin
          next_state = URA_S_CMD;
        end
      end
      URA_S_CMD: begin
        next_state = URA_S_ACK;
      end
      URA_S_ACK: begin
        if (stp) begin
          next_state = URA_S_IDLE;
        end else if (ext) begin
          next_state = URA_S_EADDR;
        end else if (is_wr) begin
          next_state = URA_S_WDATA;
        end else begin
          next_state = URA_S_RTURN;
        end
      end
      URA_S_EADDR: begin
        next_state = is_wr ? URA_S_WDATA : URA_S_RTURN;
      end
      URA_S_WDATA: begin
        next_state = URA_S_WSTP;
      end
      URA_S_WSTP: begin
        // hold the byte until the link ends the packet
        if (stp) begin
          next_state = URA_S_COMMIT;
        end
      end
      URA_S_COMMIT: begin
        next_state = URA_S_IDLE;
      end
      URA_S_RTURN: begin
        next_state = URA_S_RDRIVE;
      end
      URA_S_RDRIVE: begin
        next_state = URA_S_RBACK;
      end
      URA_S_RBACK: begin
        // bus content of this cycle is never decoded
        next_state = URA_S_IDLE;
      end
      URA_S_TXPKT: begin
        // packet bytes belong to the transmit path, not to us
        if (stp) begin
          next_state = URA_S_IDLE;
        end
      end
      default: begin
        next_state = URA_S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= URA_S_IDLE;
      kind  <= URA_K_IDLE;
      ext   <= 1'b0;
      addr  <= `URA_BYTE_RST;
      wdata <= `URA_BYTE_RST;
    end else if (clk_en) begin
      state <= next_state;
      if (cmd_seen) begin
        kind <= cmd_now.kind;
        ext  <= cmd_now.ext;
        addr <= cmd_now.addr;
      end
      if (take_addr) begin
        addr <= data_in;
      end
      if (take_data) begin
        wdata <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // notices to the rest of the transceiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_start    <= 1'b0;
      tx_nopid    <= 1'b0;
      tx_pid      <= `URA_PID_RST;
      reg_wr      <= 1'b0;
      reg_wr_addr <= `URA_BYTE_RST;
      reg_wr_data <= `URA_BYTE_RST;
    end else if (clk_en) begin
      tx_start <= cmd_seen && (cmd_now.kind == URA_K_TX) && tx_legal;
      reg_wr   <= mem_we;
      if (cmd_seen && cmd_now.kind == URA_K_TX) begin
        tx_nopid <= cmd_now.nopid;
        tx_pid   <= cmd_now.pid;
      end
      if (mem_we) begin
        reg_wr_addr <= addr;
        reg_wr_data <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  // no mode input reaches the array, so its contents persist
  ura_regmem u_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .we      (mem_we),
    .waddr   (addr),
    .wdata   (wdata),
    .re      (mem_re),
    .raddr   (addr),
    .rdata   (data_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire logic wr_busy = (state == URA_S_WDATA) || (state == URA_S_WSTP) ||
                       (state == URA_S_COMMIT) || (is_wr && state != URA_S_IDLE);

  a_write_dir_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_busy |-> !dir)
    else $error("dir raised during a register write");

  a_imm_wr_nxt: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_CMD && is_wr && !ext) ##1 (clk_en && !stp) ##1 clk_en
      ##1 (clk_en && stp)
      |-> (nxt && $past(nxt, 1) && $past(nxt, 2)) ##1 !nxt)
    else $error("immediate write nxt window wrong");

  a_wr_nxt_shape: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_CMD && is_wr) ##1 (clk_en && !stp)[*3]
      |-> (nxt && $past(nxt, 1) && $past(nxt, 2)) ##1 (nxt == !ext))
    else $error("write nxt sequence wrong");

  // only the first commit cycle counts; a frozen enable may hold commit
  a_commit_after_stp: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(mem_we) |-> $past(stp) && $past(state) == URA_S_WSTP)
    else $error("register written without stp");

  a_imm_rd_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_CMD && is_rd && !ext) ##1 (clk_en && !stp) ##1 clk_en[*2]
      |-> ($past(dir && !nxt && !data_oe) && dir && data_oe) ##1 !dir)
    else $error("immediate read dir timing wrong");

  a_ext_rd_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_CMD && is_rd && ext) ##1 (clk_en && !stp) ##1 clk_en[*3]
      |-> ($past(nxt && !dir, 3) && $past(nxt && !dir, 2) &&
           $past(dir && !nxt && !data_oe, 1) && dir && data_oe) ##1 !dir)
    else $error("extended read dir timing wrong");

  a_turn_no_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dir != $past(dir)) |-> !data_oe)
    else $error("bus driven in a turnaround cycle");

  a_drive_owns_bus: assert property (@(posedge clk_sys) disable iff (!resetn)
    data_oe |-> dir && $past(dir) && !nxt)
    else $error("bus driven without ownership");

  a_nopid_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_IDLE && data_in == 8'h40) |=> tx_start && tx_nopid)
    else $error("nopid transmit not flagged");

  a_pid_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_IDLE && data_in[7:4] == 4'h4) |=>
      tx_start && tx_pid == $past(data_in[3:0]))
    else $error("pid not taken from low nibble");

  a_ext_addr_take: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_IDLE && data_in[7] && data_in[5:0] == 6'h2f)
      |=> ##2 (clk_en && state == URA_S_EADDR) |=> addr == $past(data_in))
    else $error("extended address not captured");

  a_wdata_take: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_WDATA) |=> wdata == $past(data_in))
    else $error("write data byte not captured");

  a_wr_notice: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && mem_we) |=> reg_wr && reg_wr_addr == $past(addr) &&
      reg_wr_data == $past(wdata))
    else $error("write notice does not match the committed byte");

  // abort only in the first nxt cycle, before any byte is owed
  a_stp_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_ACK && stp) |=> state == URA_S_IDLE && !nxt && !dir)
    else $error("stp in the first nxt cycle did not abort");

  a_idle_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == URA_S_IDLE && data_in[7:6] == 2'b00) |=> state == URA_S_IDLE)
    else $error("idle byte taken as a command");

endmodule : ura_ulpi_regacc

`default_nettype wire

//--- bench/ura_link_model.sv
// link controller model driving the ulpi bus toward the transceiver
`default_nettype none

module ura_link_model (
  // clock
  input  wire logic       clk_sys,
  // ulpi bus
  input  wire logic       dir,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  output logic      [7:0] data_in,
  output logic            stp
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       link_oe   = 1'b1;
  logic [7:0] link_byte = 8'h00;
  logic [7:0] bus_last  = 8'h00;

  initial stp = 1'b0;

  // released bus shows the inverse of its last level, so no stale byte passes
  always @(posedge clk_sys) bus_last <= data_in;

  always_comb begin
    if (data_oe)
      data_in = data_out;
    else if (link_oe && !dir)
      data_in = link_byte;
    else
      data_in = ~bus_last;
  end

  // drive a byte, stp held at the level asked until the next put or float
  task put(input logic [7:0] b, input logic s);
    link_oe = 1'b1;
    link_byte = b;
    stp = s;
  endtask : put

  // let go of the bus while the transceiver owns it
  task float();
    link_oe = 1'b0;
    stp = 1'b0;
  endtask : float
endmodule : ura_link_model

`default_nettype wire

//--- bench/ura_ulpi_regacc_tb_top.sv
// self-checking bench for the ulpi register access sequencer
`default_nettype none

module ura_ulpi_regacc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals and cases
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ew;
    logic       er;
    logic [7:0] addr;
    logic [7:0] data;
  } ura_row_t;

  logic       clk_sys, resetn, clk_en, data_oe, dir, nxt, stp;
  logic       tx_start, tx_nopid, reg_wr;
  logic [3:0] tx_pid;
  logic [7:0] data_in, data_out, reg_wr_addr, reg_wr_data;
  int         n_fail = 0;
  int         n_compared = 0;

  // write path and read path per row; 2fh is reachable only as extended
  ura_row_t   rows [6] = '{
    {1'b0, 1'b1, 8'h05, 8'h5a},
    {1'b0, 1'b0, 8'h3f, 8'ha5},
    {1'b1, 1'b1, 8'h2f, 8'h3c},
    {1'b1, 1'b1, 8'hff, 8'hc3},
    {1'b1, 1'b0, 8'h00, 8'h01},
    {1'b0, 1'b1, 8'h2e, 8'h80}
  };
  logic [7:0] tx_cmds [5] = '{8'h40, 8'h43, 8'h4f, 8'h53, 8'h7f};

  ura_ulpi_regacc u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .dir(dir), .nxt(nxt), .stp(stp),
    .tx_start(tx_start), .tx_nopid(tx_nopid), .tx_pid(tx_pid),
    .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data)
  );

  ura_link_model u_link (
    .clk_sys(clk_sys), .dir(dir), .data_oe(data_oe),
    .data_out(data_out), .data_in(data_in), .stp(stp)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic ext, input logic [7:0] a, input logic [7:0] d);
    u_link.put(ext ? 8'haf : {2'b10, a[5:0]}, 1'b0);
    step();
    chk("nxt_c1", nxt, 1'b0);
    step();
    chk("nxt_ack", nxt, 1'b1);
    step();
    u_link.put(ext ? a : d, 1'b0);
    chk("dir_wr", dir, 1'b0);
    if (ext) begin
      step();
      u_link.put(d, 1'b0);
      chk("nxt_ext", nxt, 1'b1);
    end
    step();
    u_link.put(8'h00, 1'b1);
    chk("nxt_stp", nxt, !ext);
    step();
    u_link.put(8'h00, 1'b0);
    chk("nxt_end", nxt, 1'b0);
    chk("wr_early", reg_wr, 1'b0);
    step();
    chk("reg_wr", reg_wr, 1'b1);
    chk("wr_addr", reg_wr_addr, ext ? a : {2'b00, a[5:0]});
    chk("wr_data", reg_wr_data, d);
    chk("dir_wr", dir, 1'b0);
    step();
  endtask : wr

  task automatic rd(input logic ext, input logic [7:0] a, input logic [7:0] e, input int hold);
    u_link.put(ext ? 8'hef : {2'b11, a[5:0]}, 1'b0);
    step();
    chk("nxt_c1", nxt, 1'b0);
    step();
    chk("nxt_ack", nxt, 1'b1);
    if (ext) begin
      step();
      u_link.put(a, 1'b0);
      chk("dir_eaddr", {dir, nxt}, 2'b01);
    end
    step();
    u_link.float();
    chk("dir_up", {dir, nxt, data_oe}, 3'b100);
    repeat (hold) begin
      clk_en = 1'b0;
      step();
      chk("dir_hold", {dir, data_oe}, 2'b10);
    end
    clk_en = 1'b1;
    step();
    chk("data_oe", data_oe, 1'b1);
    chk("rd_data", data_out, e);
    step();
    chk("dir_down", {dir, data_oe}, 2'b00);
    step();
    u_link.put(8'h00, 1'b0);
    step();
  endtask : rd

  // packet byte c5h mimics a read; it must not be taken as a command
  task automatic tx(input logic [7:0] c);
    logic ok;
    ok = (c[5:4] == 2'b00);
    u_link.put(c, 1'b0);
    step();
    chk("tx_start", tx_start, ok);
    if (ok) begin
      chk("tx_pid", tx_pid, c[3:0]);
      chk("tx_nopid", tx_nopid, c == 8'h40);
    end
    u_link.put(ok ? 8'hc5 : 8'h00, 1'b0);
    step();
    chk("nxt_tx", {nxt, dir}, 2'b00);
    u_link.put(8'h00, ok);
    step();
    u_link.put(8'h00, 1'b0);
    step();
  endtask : tx

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("rst_out", {dir, nxt, data_oe, reg_wr, tx_start}, 5'h00);
    resetn = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].ew, rows[i].addr, rows[i].data);
      $display("write row %0d done", i);
    end
    foreach (rows[i]) begin
      rd(rows[i].er, rows[i].addr, rows[i].data, 0);
      $display("read row %0d done", i);
    end
    foreach (tx_cmds[i]) begin
      tx(tx_cmds[i]);
      $display("transmit %h done", tx_cmds[i]);
    end
    // frozen clock enable must hold the turnaround
    rd(1'b0, 8'h3f, 8'ha5, 3);
    $display("clock enable hold done");
    // stp in the first nxt cycle aborts the write without a commit
    u_link.put(8'h85, 1'b0);
    repeat (2) step();
    u_link.put(8'h00, 1'b1);
    chk("nxt_abort", nxt, 1'b1);
    step();
    u_link.put(8'h00, 1'b0);
    chk("nxt_after", nxt, 1'b0);
    repeat (2) step();
    chk("wr_abort", reg_wr, 1'b0);
    $display("write abort done");
    // reset in mid-read drops dir at once; array keeps its contents
    u_link.put(8'hc5, 1'b0);
    repeat (3) step();
    chk("dir_pre", dir, 1'b1);
    u_link.float();
    resetn = 1'b0;
    #1;
    chk("rst_mid", {dir, nxt, data_oe}, 3'b000);
    u_link.put(8'h00, 1'b0);
    step();
    resetn = 1'b1;
    rd(1'b1, 8'h05, 8'h5a, 0);
    $display("mid-run reset done");
    final_report();
  end

  // watchdog, far beyond the 150 or so cycles the tests need
  initial begin
    #(100 * 2000);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    final_report();
  end
endmodule : ura_ulpi_regacc_tb_top

`default_nettype wire
